// File: logic/dlc2_bit_div.v
`timescale 1ns/1ps
`default_nettype none
`include "dlc2_defs.vh"

// one-cycle enable every DIV clocks
module dlc2_bit_div #(
    parameter integer DIV = `DLC2_BIT_DIV
) (
    input wire clk_i,
    input wire rst_i,
    output reg tick_o
);
    reg [15:0] cnt_reg;

    // free running divider
    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= 16'h0000;
            tick_o <= 1'b0;
        end else if (cnt_reg == DIV[15:0] - 16'h0001) begin
            cnt_reg <= 16'h0000;
            tick_o <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 16'h0001;
            tick_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: logic/dlc2_defs.vh
`ifndef DLC2_DEFS_VH
`define DLC2_DEFS_VH

// register byte addresses
`define DLC2_ADDR_CTRL 12'h000
`define DLC2_ADDR_STAT 12'h004
`define DLC2_ADDR_WIDTH 12

// control register field positions
`define DLC2_BIT_LC_EN 7
`define DLC2_BIT_AUTO_ABORT_OFF 6
`define DLC2_BIT_RX_CHECK_OFF 5
`define DLC2_BIT_RX_REPEAT_DISCARD 4
`define DLC2_BIT_TX_ABORT 3
`define DLC2_CTRL_WMASK 8'hF8
`define DLC2_CTRL_RESET 8'h00

// framing format codes
`define DLC2_FMT_SF 2'h0
`define DLC2_FMT_ESF 2'h1
`define DLC2_FMT_LC 2'h2

// hdlc octets
`define DLC2_FLAG 8'h7E
`define DLC2_ABORT 8'hFE
`define DLC2_ABORT_BITS 4'h8

// message type codes on the transmit source
`define DLC2_MSG_NONE 2'h0
`define DLC2_MSG_MOS 2'h1
`define DLC2_MSG_BOS 2'h2
`define DLC2_MSG_LAPD 2'h3

// line bit rate and derived enable divisor
`define DLC2_CLK_HZ 40000000
`define DLC2_LINE_HZ 4000
`define DLC2_BIT_DIV (`DLC2_CLK_HZ / `DLC2_LINE_HZ)

`endif

// File: logic/dlc2_sync.v
`timescale 1ns/1ps
`default_nettype none

// two flip-flop level synchroniser
module dlc2_sync #(
    parameter integer W = 1
) (
    input wire clk_i,
    input wire rst_i,
    input wire [W-1:0] d_i,
    output reg [W-1:0] q_o
);
    reg [W-1:0] meta_reg;

    // first stage feeds only the second
    always @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= {W{1'b0}};
            q_o <= {W{1'b0}};
        end else begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// File: logic/dlc2_top.v
`timescale 1ns/1ps
`default_nettype none
`include "dlc2_defs.vh"

module dlc2_top #(
    parameter integer BIT_DIV = `DLC2_BIT_DIV
) (
    input wire CORE_CLK_I,
    input wire RST_I,
    // apb slave
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PWRITE_I,
    input wire [11:0] PADDR_I,
    input wire [31:0] PWDATA_I,
    output reg [31:0] PRDATA_O,
    output reg PREADY_O,
    output reg PSLVERR_O,
    // channel framing format
    input wire [1:0] FRAME_FMT_I,
    // transmit message source
    input wire [1:0] TX_MSG_TYPE_I,
    input wire TX_MSG_BIT_I,
    input wire TX_MSG_VALID_I,
    output reg TX_MSG_TAKE_O,
    output reg TX_SF_BIT_O,
    // line side
    output reg TX_DL_BIT_O,
    output reg TX_DL_LC_O,
    input wire RX_DL_BIT_I,
    input wire RX_FRAME_END_I,
    input wire RX_FCS_OK_I,
    input wire [1:0] RX_MSG_TYPE_I,
    input wire [7:0] RX_MSG_SIG_I,
    // receive decisions
    output reg RX_DL_LC_O,
    output reg RX_DL_BIT_O,
    output reg RX_ACCEPT_O,
    output reg RX_FCS_ERR_O,
    output reg RX_DISCARD_O
);
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_DATA = 4'h2;
    localparam [3:0] ST_ABORT = 4'h4;
    localparam [3:0] ST_FLAG = 4'h8;

    // bit-rate enable and synchronised line inputs
    wire tick;
    wire [15:0] rx_sync;
    wire [1:0] fmt;
    wire rx_bit;
    wire rx_end;
    wire rx_ok;
    wire [1:0] rx_type;
    wire [7:0] rx_sig;

    // control register and transmit machine
    reg [7:0] ctrl_reg;
    reg [3:0] state_reg;
    reg [3:0] state_next;
    reg [7:0] shift_reg;
    reg [7:0] shift_next;
    reg [3:0] cnt_reg;
    reg [3:0] cnt_next;
    reg take_next;

    // message history for auto abort and repeat discard
    reg [1:0] last_type_reg;
    reg [7:0] held_sig_reg;
    reg held_valid_reg;

    // framing toggle and bus helpers
    reg sf_reg;
    reg lc_active;
    reg apb_wr;
    reg apb_rd;

    dlc2_bit_div #(
        .DIV(BIT_DIV)
    ) u_div (
        .clk_i(CORE_CLK_I),
        .rst_i(RST_I),
        .tick_o(tick)
    );

    // pins from the line side are resynchronised
    dlc2_sync #(
        .W(16)
    ) u_sync (
        .clk_i(CORE_CLK_I),
        .rst_i(RST_I),
        .d_i({FRAME_FMT_I, RX_DL_BIT_I, RX_FRAME_END_I, RX_FCS_OK_I, RX_MSG_TYPE_I,
              RX_MSG_SIG_I, 1'b0}),
        .q_o(rx_sync)
    );
    assign fmt = rx_sync[15:14];
    assign rx_bit = rx_sync[13];
    assign rx_end = rx_sync[12];
    assign rx_ok = rx_sync[11];
    assign rx_type = rx_sync[10:9];
    assign rx_sig = rx_sync[8:1];

    // loop-carrier enable gated by framing
    always @* begin
        lc_active = ctrl_reg[`DLC2_BIT_LC_EN] &&
            ((fmt == `DLC2_FMT_LC) || (fmt == `DLC2_FMT_ESF));
    end

    // apb strobes, one access phase with one wait state
    always @* begin
        apb_wr = PSEL_I && PENABLE_I && PWRITE_I && !PREADY_O;
        apb_rd = PSEL_I && PENABLE_I && !PWRITE_I && !PREADY_O;
    end

    // apb register file
    always @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            ctrl_reg <= `DLC2_CTRL_RESET;
            PRDATA_O <= 32'h00000000;
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
        end else begin
            PREADY_O <= apb_wr || apb_rd;
            PSLVERR_O <= 1'b0;
            if (apb_wr || apb_rd) begin
                if (PADDR_I == `DLC2_ADDR_CTRL) begin
                    if (apb_wr) begin
                        ctrl_reg <= PWDATA_I[7:0] & `DLC2_CTRL_WMASK;
                    end
                    PRDATA_O <= {24'h000000, ctrl_reg};
                end else if (PADDR_I == `DLC2_ADDR_STAT) begin
                    PRDATA_O <= {24'h000000, held_valid_reg, lc_active, state_reg, fmt};
                end else begin
                    PRDATA_O <= 32'h00000000;
                    PSLVERR_O <= 1'b1;
                end
            end else begin
                PRDATA_O <= 32'h00000000;
            end
        end
    end

    // transmit hdlc 2 next state
    always @* begin
        state_next = state_reg;
        shift_next = shift_reg;
        cnt_next = cnt_reg;
        take_next = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (cnt_reg == 4'h0) begin
                    shift_next = `DLC2_FLAG;
                    cnt_next = 4'h8;
                end else begin
                    shift_next = {1'b0, shift_reg[7:1]};
                    cnt_next = cnt_reg - 4'h1;
                end
                if (cnt_reg == 4'h1 && TX_MSG_VALID_I && lc_active) begin
                    state_next = ST_DATA;
                end
            end
            ST_DATA: begin
                // a bit is consumed only while the link carries messages
                take_next = TX_MSG_VALID_I && lc_active;
                if (TX_MSG_VALID_I && TX_MSG_TYPE_I == `DLC2_MSG_BOS &&
                    last_type_reg == `DLC2_MSG_MOS &&
                    !ctrl_reg[`DLC2_BIT_AUTO_ABORT_OFF]) begin
                    state_next = ST_ABORT;
                    shift_next = `DLC2_ABORT;
                    cnt_next = `DLC2_ABORT_BITS;
                    take_next = 1'b0;
                end else if (!TX_MSG_VALID_I || !lc_active) begin
                    state_next = ST_IDLE;
                    cnt_next = 4'h0;
                end
            end
            ST_ABORT: begin
                shift_next = {1'b1, shift_reg[7:1]};
                if (cnt_reg != 4'h0) begin
                    cnt_next = cnt_reg - 4'h1;
                end
                if (cnt_reg <= 4'h1 && !ctrl_reg[`DLC2_BIT_TX_ABORT]) begin
                    state_next = ST_FLAG;
                    shift_next = `DLC2_FLAG;
                    cnt_next = 4'h8;
                end
            end
            ST_FLAG: begin
                shift_next = {1'b0, shift_reg[7:1]};
                cnt_next = cnt_reg - 4'h1;
                if (cnt_reg == 4'h1) begin
                    state_next = ST_IDLE;
                    cnt_next = 4'h0;
                end
            end
            default: begin
                state_next = ST_IDLE;
                cnt_next = 4'h0;
            end
        endcase
        if (ctrl_reg[`DLC2_BIT_TX_ABORT] && state_reg != ST_ABORT) begin
            state_next = ST_ABORT;
            shift_next = 8'hFF;
            cnt_next = `DLC2_ABORT_BITS;
            take_next = 1'b0;
        end
    end

    // transmit state and line bit
    always @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            state_reg <= ST_IDLE;
            shift_reg <= 8'h00;
            cnt_reg <= 4'h0;
            last_type_reg <= `DLC2_MSG_NONE;
            sf_reg <= 1'b0;
            TX_DL_BIT_O <= 1'b1;
            TX_DL_LC_O <= 1'b0;
            TX_MSG_TAKE_O <= 1'b0;
            TX_SF_BIT_O <= 1'b0;
        end else begin
            TX_MSG_TAKE_O <= 1'b0;
            if (tick) begin
                state_reg <= state_next;
                shift_reg <= shift_next;
                cnt_reg <= cnt_next;
                TX_MSG_TAKE_O <= take_next;
                sf_reg <= ~sf_reg;
                if (take_next) begin
                    last_type_reg <= TX_MSG_TYPE_I;
                end else if (state_reg == ST_ABORT) begin
                    // an abort closes the mos run, so the next bos needs no second one
                    last_type_reg <= `DLC2_MSG_NONE;
                end
                TX_DL_LC_O <= lc_active;
                // line bit: message data, abort ones or the shifter
                if (state_reg == ST_DATA) begin
                    TX_DL_BIT_O <= TX_MSG_BIT_I;
                end else if (state_reg == ST_ABORT && shift_reg == 8'hFF) begin
                    TX_DL_BIT_O <= 1'b1;
                end else begin
                    TX_DL_BIT_O <= shift_reg[0];
                end
                TX_SF_BIT_O <= lc_active ? 1'b0 : sf_reg;
            end
        end
    end

    // receive hdlc 2 decisions
    always @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            held_sig_reg <= 8'h00;
            held_valid_reg <= 1'b0;
            RX_DL_LC_O <= 1'b0;
            RX_DL_BIT_O <= 1'b0;
            RX_ACCEPT_O <= 1'b0;
            RX_FCS_ERR_O <= 1'b0;
            RX_DISCARD_O <= 1'b0;
        end else begin
            RX_DL_LC_O <= lc_active;
            RX_DL_BIT_O <= lc_active ? rx_bit : 1'b0;
            // decision pulses stand for one cycle
            RX_ACCEPT_O <= 1'b0;
            RX_FCS_ERR_O <= 1'b0;
            RX_DISCARD_O <= 1'b0;
            if (rx_end && lc_active) begin
                if (!ctrl_reg[`DLC2_BIT_RX_CHECK_OFF] && !rx_ok) begin
                    RX_FCS_ERR_O <= 1'b1;
                end else if (ctrl_reg[`DLC2_BIT_RX_REPEAT_DISCARD] && held_valid_reg &&
                    (rx_type == `DLC2_MSG_BOS || rx_type == `DLC2_MSG_LAPD) &&
                    rx_sig == held_sig_reg) begin
                    RX_DISCARD_O <= 1'b1;
                end else begin
                    RX_ACCEPT_O <= 1'b1;
                    held_sig_reg <= rx_sig;
                    held_valid_reg <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: test/dlc2_far_end.sv
`timescale 1ns/1ps
`default_nettype none
// remote terminal: sends one received frame per send pulse
module dlc2_far_end (
    input wire logic clk_i,
    input wire logic send_i,
    input wire logic fcs_ok_i,
    input wire logic [1:0] type_i,
    input wire logic [7:0] sig_i,
    output logic bit_o = 1'b0,
    output logic frame_end_o = 1'b0,
    output logic fcs_ok_o = 1'b0,
    output logic [1:0] type_o = 2'h0,
    output logic [7:0] sig_o = 8'h00
);
    // fields invert once the frame end has passed
    always @(posedge clk_i) begin
        bit_o <= ~bit_o;
        frame_end_o <= send_i;
        if (send_i) begin
            fcs_ok_o <= fcs_ok_i;
            type_o <= type_i;
            sig_o <= sig_i;
        end else if (frame_end_o) begin
            fcs_ok_o <= ~fcs_ok_o;
            type_o <= ~type_o;
            sig_o <= ~sig_o;
        end
    end
endmodule
`default_nettype wire

// File: test/dlc2_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "dlc2_defs.vh"
// port-level checks on the control block
module dlc2_monitor (
    input wire CORE_CLK_I,
    input wire RST_I,
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PREADY_O,
    input wire PSLVERR_O,
    input wire [1:0] FRAME_FMT_I,
    input wire RX_FRAME_END_I,
    input wire RX_FCS_OK_I,
    input wire TX_MSG_TAKE_O,
    input wire TX_SF_BIT_O,
    input wire TX_DL_BIT_O,
    input wire TX_DL_LC_O,
    input wire RX_DL_LC_O,
    input wire RX_ACCEPT_O,
    input wire RX_FCS_ERR_O,
    input wire RX_DISCARD_O
);
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (RST_I);
    // apb answer timing
    a_ready_answer: assert property (PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O)
        else $error("ready missing after access");
    a_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready longer than one cycle");
    a_err_ready: assert property (PSLVERR_O |-> PREADY_O)
        else $error("error without ready");
    a_reset_line: assert property (disable iff (1'b0) RST_I |=> TX_DL_BIT_O && !TX_DL_LC_O)
        else $error("line not idle after reset");
    a_sf_ignored: assert property (
        (FRAME_FMT_I == `DLC2_FMT_SF) [*4] |-> !RX_DL_LC_O)
        else $error("loop-carrier active in sf format");
    a_sf_quiet: assert property (TX_DL_LC_O |-> !TX_SF_BIT_O)
        else $error("sf bits sent while loop-carrier");
    a_take_lc: assert property (TX_MSG_TAKE_O |-> TX_DL_LC_O)
        else $error("message bit taken while inactive");
    a_fcs_cause: assert property (
        RX_FCS_ERR_O |-> $past(RX_FRAME_END_I, 3) && !$past(RX_FCS_OK_I, 3))
        else $error("fcs error without bad frame");
    a_one_decision: assert property (
        $onehot0({RX_ACCEPT_O, RX_FCS_ERR_O, RX_DISCARD_O}))
        else $error("two decisions for one frame");
endmodule
bind dlc2_top dlc2_monitor mon (.CORE_CLK_I, .RST_I, .PSEL_I, .PENABLE_I, .PREADY_O,
    .PSLVERR_O, .FRAME_FMT_I, .RX_FRAME_END_I, .RX_FCS_OK_I, .TX_MSG_TAKE_O, .TX_SF_BIT_O,
    .TX_DL_BIT_O, .TX_DL_LC_O, .RX_DL_LC_O, .RX_ACCEPT_O, .RX_FCS_ERR_O, .RX_DISCARD_O);
`default_nettype wire

// File: test/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "dlc2_defs.vh"
module tb;
    localparam int DIV = 4;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, send = 0, fok = 0, err;
    logic txb = 0, txv = 0;
    logic [11:0] padr = 12'h000;
    logic [31:0] pwd = 32'h0, rd;
    logic [1:0] fmt = 2'h1, txt = 2'h0, rxt = 2'h0, rxty;
    logic [7:0] sig = 8'h00, rxsig;
    logic [31:0] prdata;
    logic pready, pslverr, take, sfb, dlb, dllc, rxb, rxe, rxok, rlc, rdb, acc, ferr, disc;
    int n_errors = 0, total_checks = 0, mx, on, nt;
    always #12.5 clk = ~clk;
    dlc2_top #(.BIT_DIV(DIV)) uut (.CORE_CLK_I(clk), .RST_I(rst), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .FRAME_FMT_I(fmt), .TX_MSG_TYPE_I(txt),
        .TX_MSG_BIT_I(txb), .TX_MSG_VALID_I(txv), .TX_MSG_TAKE_O(take), .TX_SF_BIT_O(sfb),
        .TX_DL_BIT_O(dlb), .TX_DL_LC_O(dllc), .RX_DL_BIT_I(rxb), .RX_FRAME_END_I(rxe),
        .RX_FCS_OK_I(rxok), .RX_MSG_TYPE_I(rxty), .RX_MSG_SIG_I(rxsig), .RX_DL_LC_O(rlc),
        .RX_DL_BIT_O(rdb), .RX_ACCEPT_O(acc), .RX_FCS_ERR_O(ferr), .RX_DISCARD_O(disc));
    dlc2_far_end far (.clk_i(clk), .send_i(send), .fcs_ok_i(fok), .type_i(rxt), .sig_i(sig),
        .bit_o(rxb), .frame_end_o(rxe), .fcs_ok_o(rxok), .type_o(rxty), .sig_o(rxsig));
    // compare and count
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task give_verdict;
        if (n_errors == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // one apb transfer, held until ready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1; pen <= 0; pwr <= w; padr <= a; pwd <= d;
        @(posedge clk);
        pen <= 1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            chk("apb wait", 0, 1);
            give_verdict;
        end
        rd = prdata; err = pslverr; psel <= 0; pen <= 0;
    endtask
    // sample line bits once per bit time, longest run of ones
    task line(input int n);
        int r;
        mx = 0; on = 0; r = 0; nt = 0;
        repeat (n) begin
            repeat (DIV) begin
                @(posedge clk);
                nt += take;
            end
            if (dlb === 1'b1) begin r++; on++; end else r = 0;
            if (r > mx) mx = r;
        end
    endtask
    // far end sends a frame, decision {accept,fcs,discard} judged
    task frame(input logic ok, input logic [1:0] t, input logic [7:0] s, input logic [2:0] e);
        logic [2:0] g;
        g = 3'h0; fok <= ok; rxt <= t; sig <= s; send <= 1;
        @(posedge clk) send <= 0;
        for (int i = 0; i < 20 && g === 3'h0; i++) begin
            @(posedge clk);
            g = {acc, ferr, disc};
        end
        chk("rx decision", g, e);
    endtask
    task s_regs;
        apb(0, `DLC2_ADDR_CTRL, 0); chk("ctrl reset", rd, 32'h00);
        apb(1, `DLC2_ADDR_CTRL, 32'hFF); apb(0, `DLC2_ADDR_CTRL, 0); chk("ctrl rw", rd, 32'hF8);
        apb(0, 12'h008, 0); chk("unmapped err", err, 1); chk("unmapped rd", rd, 0);
        apb(0, `DLC2_ADDR_STAT, 0); chk("stat err", err, 0);
    endtask
    task s_fmt;
        for (int f = 0; f < 3; f++) begin
            fmt <= f[1:0]; apb(1, `DLC2_ADDR_CTRL, 32'h80); repeat (10) @(posedge clk);
            chk("tx lc", dllc, f != 0);
            chk("rx lc", rlc, f != 0);
            chk("rx bit", rdb, (f != 0) ? !rxb : 1'b0);
        end
        apb(1, `DLC2_ADDR_CTRL, 32'h00); line(8);
        chk("lc off", dllc, 0);
        on = 0;
        repeat (8 * DIV) begin @(posedge clk); on += sfb; end
        chk("sf toggles", on > 0 && on < 8 * DIV, 1);
    endtask
    task s_rx;
        apb(1, `DLC2_ADDR_CTRL, 32'h80); repeat (10) @(posedge clk);
        frame(0, `DLC2_MSG_BOS, 8'h5A, 3'b010);
        apb(1, `DLC2_ADDR_CTRL, 32'hA0); frame(0, `DLC2_MSG_BOS, 8'h5A, 3'b100);
        apb(1, `DLC2_ADDR_CTRL, 32'h90); frame(1, `DLC2_MSG_BOS, 8'h5A, 3'b001);
        frame(1, `DLC2_MSG_LAPD, 8'hC3, 3'b100);
        frame(1, `DLC2_MSG_LAPD, 8'hC3, 3'b001);
        frame(1, `DLC2_MSG_MOS, 8'hC3, 3'b100);
        apb(1, `DLC2_ADDR_CTRL, 32'h80); frame(1, `DLC2_MSG_LAPD, 8'hC3, 3'b100);
    endtask
    task s_abort;
        apb(1, `DLC2_ADDR_CTRL, 32'h88); line(16); line(16);
        chk("abort ones", on, 16);
        apb(1, `DLC2_ADDR_CTRL, 32'h80); line(12);
        chk("flags back", on < 12, 1);
    endtask
    // mos data then abrupt bos, abort on and off
    task s_mos(input logic [31:0] c, input int e);
        apb(1, `DLC2_ADDR_CTRL, c); txv <= 1; txt <= `DLC2_MSG_MOS; line(20);
        txt <= `DLC2_MSG_BOS; line(16);
        chk("max ones run", mx, e);
        if (c[6]) chk("bits taken", nt, 16);
        txv <= 0; txt <= `DLC2_MSG_NONE; line(16);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 0;
        s_regs; s_fmt; s_rx; s_abort;
        s_mos(32'h80, 7);
        s_mos(32'hC0, 0);
        give_verdict;
    end
endmodule
`default_nettype wire
